// ===== xpc_defines.svh
`ifndef XPC_DEFINES_SVH
`define XPC_DEFINES_SVH

// Clock period of sys_clk.
`define XPC_CLK_PERIOD_NS 10

// Pin timing of the switch, in ns as the part needs them.
`define XPC_T_DATA_SETUP_NS 20
`define XPC_T_DATA_HOLD_NS 25
`define XPC_T_WR_HIGH_NS 20
`define XPC_T_LATCH_WIDTH_NS 40
`define XPC_T_LATCH_DELAY_NS 40

// Least times round up to whole cycles.
`define XPC_CYC(ns) (((ns) + `XPC_CLK_PERIOD_NS - 1) / `XPC_CLK_PERIOD_NS)
`define XPC_SETUP_CYC `XPC_CYC(`XPC_T_DATA_SETUP_NS)
`define XPC_HIGH_CYC \
  ((`XPC_CYC(`XPC_T_DATA_HOLD_NS) > `XPC_CYC(`XPC_T_WR_HIGH_NS)) ? \
   `XPC_CYC(`XPC_T_DATA_HOLD_NS) : `XPC_CYC(`XPC_T_WR_HIGH_NS))
`define XPC_LATCH_LOW_CYC `XPC_CYC(`XPC_T_LATCH_WIDTH_NS)
`define XPC_LATCH_GAP_CYC `XPC_CYC(`XPC_T_LATCH_DELAY_NS)

// Frame and field sizes.
`define XPC_FRAME_BITS 32
`define XPC_OUTPUTS 8
`define XPC_CODE_BITS 4

// Code values.
`define XPC_CODE_SER_ENABLE 4'h9
`define XPC_CODE_SER_DISABLE 4'hA
`define XPC_CODE_FIRST_SER_BAD 4'hB

`endif

// ===== xpc_pkg.sv
`default_nettype none

package xpc_pkg;

  // Kind of order taken from the user side.
  typedef enum logic [1:0] {
    XPC_PARALLEL,
    XPC_SERIAL,
    XPC_TRANSFER
  } xpc_kind_type;

  // One user order: a parallel word, a serial frame or a transfer pulse.
  typedef struct packed {
    xpc_kind_type kind;
    logic [2:0] output_select;
    logic [3:0] code_bits;
    logic [31:0] frame;
  } xpc_cmd_type;

  // Pins that the controller drives towards the switch.
  typedef struct packed {
    logic wr;
    logic ce_high;
    logic ce_low_n;
    logic latch;
    logic serial_select;
    logic edge_level_select;
    logic [2:0] output_select;
    logic [3:0] code_bits;
  } xpc_pins_type;

  typedef enum logic [2:0] {
    XPC_ST_IDLE,
    XPC_ST_SETUP,
    XPC_ST_HIGH,
    XPC_ST_GAP,
    XPC_ST_LATCH_LOW
  } xpc_fsm_type;

  // Whole state of the sequencer.
  typedef struct packed {
    xpc_fsm_type fsm;
    xpc_kind_type kind;
    logic [5:0] bit_idx;
    logic [31:0] shreg;
    logic [31:0] readback;
    logic done;
    logic error;
    xpc_pins_type pins;
  } xpc_state_type;

  // Whole state of the interval timer.
  typedef struct packed {
    logic [3:0] cnt;
  } xpc_timer_state_type;

endpackage : xpc_pkg

`default_nettype wire

// ===== xpc_timer.sv
`default_nettype none

module xpc_timer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Load and expiry.
  input wire logic load,
  input wire logic [3:0] value,
  output logic expired
);

  xpc_pkg::xpc_timer_state_type state;
  xpc_pkg::xpc_timer_state_type next_state;

  // A load of N-1 expires in the N-th cycle after the load.
  always_comb begin
    next_state = state;
    if (load) begin
      next_state.cnt = value;
    end else if (state.cnt != 4'h0) begin
      next_state.cnt = state.cnt - 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Expiry comes from the count alone. The sequencer derives its load from expiry,
  // so a term in load here would close a combinational loop. Each load enters a
  // state in which the loaded count is already present, so no stale zero is seen.
  assign expired = (state.cnt == 4'h0);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_timer_counts_down: assert property (load && value == 4'h2 |=> !expired ##1 !expired
    ##1 expired) else $error("Timer did not expire after three cycles.");

endmodule : xpc_timer

`default_nettype wire

// ===== xpc_ctrl.sv
// Summary of operation
// - Never send 1001 or 1010 in parallel.
// - Serial frame: output 0 top bit first.
// - Serial mode sends only codes 0000-1010.
// - 1010 disables; reprogram after re-enabling.
// - Stage outputs separately, then one transfer pulse.
`default_nettype none
`include "xpc_defines.svh"

module xpc_ctrl (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // User orders.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire xpc_pkg::xpc_cmd_type cmd,
  input wire logic edge_mode,
  // User answers.
  output logic cmd_done,
  output logic cmd_error,
  output logic [31:0] readback,
  // Switch control pins.
  output logic wr,
  output logic ce_high,
  output logic ce_low_n,
  output logic latch,
  output logic serial_select,
  output logic edge_level_select,
  output logic [2:0] output_select,
  output logic [3:0] code_bits,
  output logic code_bit1_oe_n,
  input wire logic shift_out_pin
);

  xpc_pkg::xpc_state_type state;
  xpc_pkg::xpc_state_type next_state;
  logic tmr_load;
  logic [3:0] tmr_value;
  logic tmr_expired;
  logic [7:0] nib_bad;
  logic frame_bad;

  // Codes kept for serial programming are refused in parallel mode.
  function automatic logic xpc_par_code_bad(input logic [3:0] code);
    xpc_par_code_bad = (code == `XPC_CODE_SER_ENABLE) || (code == `XPC_CODE_SER_DISABLE);
  endfunction : xpc_par_code_bad

  // Each nibble of a frame is checked on its own for a parallel-only code.
  for (genvar g = 0; g < `XPC_OUTPUTS; g++) begin : g_nib
    assign nib_bad[g] = cmd.frame[g*4 +: 4] >= `XPC_CODE_FIRST_SER_BAD;
  end
  assign frame_bad = |nib_bad;

  xpc_timer u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .load(tmr_load),
    .value(tmr_value),
    .expired(tmr_expired)
  );

  // Sequencer: setup, write high, optional gap and transfer pulse.
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    next_state.error = 1'b0;
    tmr_load = 1'b0;
    tmr_value = 4'h0;
    case (state.fsm)
      xpc_pkg::XPC_ST_IDLE: begin
        next_state.pins.edge_level_select = edge_mode;
        if (cmd_valid) begin
          next_state.kind = cmd.kind;
          next_state.bit_idx = 6'h00;
          if (cmd.kind == xpc_pkg::XPC_PARALLEL && xpc_par_code_bad(cmd.code_bits)) begin
            next_state.error = 1'b1;
          end else if (cmd.kind == xpc_pkg::XPC_SERIAL && frame_bad) begin
            next_state.error = 1'b1;
          end else if (cmd.kind == xpc_pkg::XPC_TRANSFER) begin
            next_state.fsm = xpc_pkg::XPC_ST_GAP;
            tmr_load = 1'b1;
            tmr_value = 4'(`XPC_LATCH_GAP_CYC - 1);
          end else begin
            next_state.fsm = xpc_pkg::XPC_ST_SETUP;
            tmr_load = 1'b1;
            tmr_value = 4'(`XPC_SETUP_CYC - 1);
            next_state.pins.serial_select = (cmd.kind == xpc_pkg::XPC_SERIAL);
            next_state.pins.output_select = cmd.output_select;
            next_state.pins.code_bits = cmd.code_bits;
            next_state.shreg = cmd.frame;
            if (cmd.kind == xpc_pkg::XPC_SERIAL) begin
              // Output 0 top code bit leaves first.
              next_state.pins.code_bits = {3'h0, cmd.frame[31]};
            end
          end
        end
      end
      xpc_pkg::XPC_ST_SETUP: begin
        if (tmr_expired) begin
          next_state.fsm = xpc_pkg::XPC_ST_HIGH;
          next_state.pins.wr = 1'b1;
          tmr_load = 1'b1;
          tmr_value = 4'(`XPC_HIGH_CYC - 1);
        end
      end
      xpc_pkg::XPC_ST_HIGH: begin
        if (tmr_expired) begin
          next_state.pins.wr = 1'b0;
          if (state.kind == xpc_pkg::XPC_SERIAL) begin
            // The bit pushed out by the last edge is now settled.
            next_state.readback = {state.readback[30:0], shift_out_pin};
            next_state.shreg = {state.shreg[30:0], 1'b0};
            next_state.bit_idx = state.bit_idx + 6'h01;
            if (state.bit_idx == 6'(`XPC_FRAME_BITS - 1)) begin
              next_state.fsm = xpc_pkg::XPC_ST_IDLE;
              next_state.done = 1'b1;
            end else begin
              next_state.fsm = xpc_pkg::XPC_ST_SETUP;
              next_state.pins.code_bits = {3'h0, state.shreg[30]};
              tmr_load = 1'b1;
              tmr_value = 4'(`XPC_SETUP_CYC - 1);
            end
          end else begin
            next_state.fsm = xpc_pkg::XPC_ST_IDLE;
            next_state.done = 1'b1;
          end
        end
      end
      xpc_pkg::XPC_ST_GAP: begin
        if (tmr_expired) begin
          next_state.fsm = xpc_pkg::XPC_ST_LATCH_LOW;
          next_state.pins.latch = 1'b0;
          tmr_load = 1'b1;
          tmr_value = 4'(`XPC_LATCH_LOW_CYC - 1);
        end
      end
      xpc_pkg::XPC_ST_LATCH_LOW: begin
        if (tmr_expired) begin
          // Rising edge moves staging to active in edge mode.
          next_state.pins.latch = 1'b1;
          next_state.fsm = xpc_pkg::XPC_ST_IDLE;
          next_state.done = 1'b1;
        end
      end
      default: begin
        next_state.fsm = xpc_pkg::XPC_ST_IDLE;
      end
    endcase
  end

  // Transfer strobe idles high so level mode stays closed between pulses.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= '0;
      state.pins.latch <= 1'b1;
      state.pins.ce_high <= 1'b1;
      state.pins.ce_low_n <= 1'b0;
      state.pins.edge_level_select <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Handshake is combinational; everything else comes from flip-flops.
  assign cmd_ready = (state.fsm == xpc_pkg::XPC_ST_IDLE);
  assign cmd_done = state.done;
  assign cmd_error = state.error;
  assign readback = state.readback;
  assign wr = state.pins.wr;
  assign ce_high = state.pins.ce_high;
  assign ce_low_n = state.pins.ce_low_n;
  assign latch = state.pins.latch;
  assign serial_select = state.pins.serial_select;
  assign edge_level_select = state.pins.edge_level_select;
  assign output_select = state.pins.output_select;
  assign code_bits = state.pins.code_bits;
  // The switch drives code bit 1 as its shift output in serial mode.
  assign code_bit1_oe_n = state.pins.serial_select;

  // Helper count of write edges within one serial frame.
  logic [6:0] ser_edges;
  always_ff @(posedge sys_clk) begin
    if (srst || (cmd_valid && cmd_ready)) begin
      ser_edges <= 7'h00;
    end else if (wr && !$past(wr)) begin
      ser_edges <= ser_edges + 7'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_data_steady;
    $stable(code_bits) && $stable(output_select) && $stable(serial_select);
  endsequence

  sequence s_latch_pulse;
    !latch [*4] ##1 latch;
  endsequence

  // Write stays high for three cycles while address and data keep still.
  sequence s_wr_held;
    (wr && $stable(code_bits) && $stable(output_select) && $stable(serial_select)) [*3];
  endsequence

  a_wr_data_setup: assert property ($rose(wr) |-> s_data_steady and
    $past(code_bits, 2) == code_bits) else $error("Data not set up before write edge.");
  a_wr_high_hold: assert property ($rose(wr) |-> s_wr_held)
    else $error("Write high or data hold too short.");
  a_ce_gate: assert property (wr |-> ce_high && !ce_low_n)
    else $error("Write raised without both chip enables.");
  a_latch_width: assert property ($fell(latch) |-> s_latch_pulse)
    else $error("Transfer pulse not four cycles low.");
  a_latch_gap: assert property ($fell(latch) |-> !$past(wr, 1) && !$past(wr, 4))
    else $error("Transfer pulse too close to a write.");
  a_bidir_release: assert property (serial_select |-> code_bit1_oe_n && code_bits[3:1] == 3'h0)
    else $error("Code bit 1 driven in serial mode.");
  a_par_reject: assert property (cmd_valid && cmd_ready && cmd.kind == xpc_pkg::XPC_PARALLEL
    && xpc_par_code_bad(cmd.code_bits) |=> cmd_error && cmd_ready && !wr)
    else $error("Serial-only code not refused in parallel.");
  a_ser_reject: assert property (cmd_valid && cmd_ready && cmd.kind == xpc_pkg::XPC_SERIAL
    && frame_bad |=> cmd_error ##1 !$rose(wr) [*4])
    else $error("Parallel-only code not refused in serial.");
  a_ser_edge_count: assert property (cmd_done && state.kind == xpc_pkg::XPC_SERIAL
    |-> ser_edges == 7'h20) else $error("Serial frame lacks 32 write edges.");

endmodule : xpc_ctrl

`default_nettype wire

// ===== xpc_dev_model.sv
`default_nettype none

module xpc_dev_model (
  // Strobes and straps.
  input wire logic wr,
  input wire logic ce_high,
  input wire logic ce_low_n,
  input wire logic latch,
  input wire logic serial_select,
  input wire logic edge_level_select,
  // Address and data.
  input wire logic [2:0] output_select,
  input wire logic [3:0] code_bits,
  output logic shift_out_pin,
  // Switch state, output 0 in the top nibble.
  output logic [31:0] staging,
  output logic [31:0] active,
  output logic [7:0] enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic so_bit;
  wire logic wr_gated = wr & ce_high & ~ce_low_n;

  // Power-up: all outputs off, every selection on input zero.
  initial begin
    staging = '0;
    active = '0;
    enabled = '0;
    so_bit = 1'b0;
  end

  // Released pin shows the inverse, so a stale sample cannot pass.
  assign shift_out_pin = serial_select ? so_bit : ~so_bit;

  // Staging to active; enable and disable codes act per output.
  task automatic move;
    logic [3:0] c;
    for (int i = 0; i < 8; i++) begin
      c = staging[31 - 4 * i -: 4];
      if (c == 4'h9) enabled[i] = 1'b1;
      if (c == 4'hA) enabled[i] = 1'b0;
      active[31 - 4 * i -: 4] = (c > 4'h8) ? 4'h8 : c;
    end
  endtask : move

  // Everything tied to the write strobe happens on its rising edge.
  always @(posedge wr_gated) begin
    if (serial_select) begin
      so_bit = staging[31];
      staging = {staging[30:0], code_bits[0]};
    end else begin
      case (code_bits)
        4'hB: enabled[output_select] = 1'b0;
        4'hC: enabled[output_select] = 1'b1;
        4'hD: enabled = 8'h00;
        4'hE: enabled = 8'hFF;
        4'hF: if (latch) move();
        default: staging[31 - 4 * output_select -: 4] = code_bits;
      endcase
    end
    if (!edge_level_select && !latch) move();
  end

  // Edge mode moves on the rising latch edge, level mode as it falls.
  always @(posedge latch) if (edge_level_select) move();
  always @(negedge latch) if (!edge_level_select) move();
endmodule : xpc_dev_model

`default_nettype wire

// ===== tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic edge_mode = 1'b1;
  xpc_pkg::xpc_cmd_type cmd = '0;
  logic cmd_ready, cmd_done, cmd_error, wr, ce_high, ce_low_n, latch, serial_select;
  logic edge_level_select, code_bit1_oe_n, shift_out_pin, err;
  logic [2:0] output_select;
  logic [3:0] code_bits;
  logic [31:0] readback, staging, active;
  logic [7:0] enabled;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  xpc_ctrl u_xpc_ctrl (.sys_clk, .srst, .cmd_valid, .cmd_ready, .cmd, .edge_mode, .cmd_done,
    .cmd_error, .readback, .wr, .ce_high, .ce_low_n, .latch, .serial_select,
    .edge_level_select, .output_select, .code_bits, .code_bit1_oe_n, .shift_out_pin);
  xpc_dev_model u_xpc_dev_model (.wr, .ce_high, .ce_low_n, .latch, .serial_select,
    .edge_level_select, .output_select, .code_bits, .shift_out_pin, .staging, .active,
    .enabled);

  // System clock.
  always #5 sys_clk = ~sys_clk;

  task automatic give_verdict;
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One order; waits for its done or refusal under a bounded count.
  task automatic issue(input xpc_pkg::xpc_kind_type k, input logic [2:0] o,
                       input logic [3:0] c, input logic [31:0] f);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd = '{kind: k, output_select: o, code_bits: c, frame: f};
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && cmd_error !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 400) n_errors++;
    err = (cmd_error === 1'b1);
  endtask : issue

  task automatic par(input logic [2:0] o, input logic [3:0] c);
    issue(xpc_pkg::XPC_PARALLEL, o, c, 32'h0);
  endtask : par

  task automatic xfer;
    issue(xpc_pkg::XPC_TRANSFER, 3'h0, 4'h0, 32'h0);
  endtask : xfer

  task automatic t_reset;
    check({wr, latch, ce_high, ce_low_n, serial_select}, 5'h0C);
    check({enabled, active}, 40'h0);
    check({cmd_ready, cmd_done, cmd_error, edge_level_select}, 4'h9);
    check(readback, 32'h0);
  endtask : t_reset

  // Staged words wait for one transfer pulse, then all switch together.
  task automatic t_parallel;
    par(3'h3, 4'h5);
    par(3'h7, 4'h2);
    check(staging, 32'h0005_0002);
    check(active, 32'h0);
    xfer();
    check(active, 32'h0005_0002);
    check(enabled, 8'h00);
  endtask : t_parallel

  // Enable and disable commands leave the staging registers alone.
  task automatic t_enables;
    par(3'h3, 4'hC);
    check(enabled, 8'h08);
    par(3'h0, 4'hE);
    check(enabled, 8'hFF);
    par(3'h3, 4'hB);
    check(enabled, 8'hF7);
    par(3'h5, 4'hD);
    check(enabled, 8'h00);
    check(staging, 32'h0005_0002);
  endtask : t_enables

  task automatic t_ground_latch;
    par(3'h2, 4'h8);
    check({enabled, staging}, 40'h00_0085_0002);
    par(3'h0, 4'hF);
    check(active, 32'h0085_0002);
  endtask : t_ground_latch

  // Serial-only codes are refused in parallel mode.
  task automatic t_refuse;
    for (int c = 9; c < 11; c++) begin
      par(3'h1, 4'(c));
      check(err, 1'b1);
    end
    check(staging, 32'h0085_0002);
  endtask : t_refuse

  task automatic t_serial;
    par(3'h0, 4'hE);
    issue(xpc_pkg::XPC_SERIAL, 3'h0, 4'h0, 32'h9A01_2345);
    check({serial_select, code_bit1_oe_n}, 2'h3);
    check(staging, 32'h9A01_2345);
    check(readback, 32'h0085_0002);
    xfer();
    check({enabled, active}, 40'hFD_8801_2345);
    issue(xpc_pkg::XPC_SERIAL, 3'h0, 4'h0, 32'hB000_0000);
    check(err, 1'b1);
    issue(xpc_pkg::XPC_SERIAL, 3'h0, 4'h0, 32'h1234_5670);
    check(readback, 32'h9A01_2345);
  endtask : t_serial

  // Level mode: nothing moves until the transfer strobe goes low.
  task automatic t_level;
    edge_mode = 1'b0;
    @(posedge sys_clk);
    #1;
    check(edge_level_select, 1'b0);
    par(3'h4, 4'h3);
    check(active, 32'h8801_2345);
    xfer();
    check(active, 32'h1234_3670);
  endtask : t_level

  // Hang guard, far above the few hundred cycles the run needs.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_parallel();
    t_enables();
    t_ground_latch();
    t_refuse();
    t_serial();
    t_level();
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
